// ==== src/cbl_defs.vh ====
// Offsets, field positions and reset values of the configuration and boot lock block
`ifndef CBL_DEFS_VH
`define CBL_DEFS_VH

// Register byte offsets
`define CBL_OFF_EXT_IMG      8'h00
`define CBL_OFF_HIGH_IMG     8'h04
`define CBL_OFF_LOW_IMG      8'h08
`define CBL_OFF_LOCK_IMG     8'h0c
`define CBL_OFF_CFG_WR       8'h10
`define CBL_OFF_LOCK_WR      8'h14
`define CBL_OFF_MODE         8'h18
`define CBL_OFF_STATUS       8'h1c
`define CBL_OFF_ID0          8'h20
`define CBL_OFF_ID1          8'h24
`define CBL_OFF_ID2          8'h28
`define CBL_OFF_RC_CAL       8'h2c
`define CBL_OFF_EXT_EFF      8'h30
`define CBL_OFF_HIGH_EFF     8'h34
`define CBL_OFF_LOW_EFF      8'h38

// Configuration byte select codes in the write register
`define CBL_SEL_EXT          2'h0
`define CBL_SEL_HIGH         2'h1
`define CBL_SEL_LOW          2'h2

// Reset values, programmed bit reads 0
`define CBL_EXT_DEFAULT      8'hff
`define CBL_HIGH_DEFAULT     8'h99
`define CBL_LOW_DEFAULT      8'h62
`define CBL_LOCK_DEFAULT     8'hff

// Unused positions, always read 1
`define CBL_EXT_UNUSED       8'hf8
`define CBL_LOCK_UNUSED      8'hc0

// Extended byte fields
`define CBL_EXT_BROWNOUT_HI  2
`define CBL_EXT_BROWNOUT_LO  1
`define CBL_EXT_RESET_DIS    0

// High byte fields
`define CBL_HIGH_DEBUG_EN    7
`define CBL_HIGH_SCAN_EN     6
`define CBL_HIGH_SERIAL_EN   5
`define CBL_HIGH_WDOG_ON     4
`define CBL_HIGH_EE_KEEP     3
`define CBL_HIGH_BOOT_SZ_HI  2
`define CBL_HIGH_BOOT_SZ_LO  1
`define CBL_HIGH_RST_VEC     0

// Low byte fields
`define CBL_LOW_DIV8         7
`define CBL_LOW_CLK_OUT      6

// Lock byte fields
`define CBL_LOCK_BOOT_UPPER  5
`define CBL_LOCK_BOOT_LOWER  4
`define CBL_LOCK_APP_FIRST   0

// Mode register fields
`define CBL_MODE_PROG        0
`define CBL_MODE_SERIAL      1
`define CBL_MODE_ERASE       2

// AXI responses
`define CBL_RESP_OKAY        2'h0
`define CBL_RESP_SLVERR      2'h2

`endif

// ==== src/cbl_boot_gate.v ====
// Boot section lock gate for self-programming writes, program reads and interrupts
`timescale 1ns/100ps

module cbl_boot_gate
(
	input  wire clk,
	input  wire rst_b,
	input  wire boot_lock_upper,
	input  wire boot_lock_lower,
	input  wire spm_req,
	input  wire spm_target_boot,
	input  wire lpm_req,
	input  wire lpm_target_boot,
	input  wire exec_in_boot,
	input  wire ivec_in_app,
	output reg  spm_grant_reg,
	output reg  lpm_grant_reg,
	output reg  int_block_reg
);

	wire block_write;
	wire block_read;

	// Mode decode: 11 free, 10 no write, 00 no write no read, 01 no read
	assign block_write = ~boot_lock_lower;
	assign block_read  = ~boot_lock_upper;

	// Registered grants, one cycle after the request
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			spm_grant_reg <= 1'b0;
			lpm_grant_reg <= 1'b0;
			int_block_reg <= 1'b0;
		end
		else
		begin
			spm_grant_reg <= spm_req & ~(spm_target_boot & block_write);
			// Reads from inside the boot section are never blocked here
			lpm_grant_reg <= lpm_req & ~(lpm_target_boot & ~exec_in_boot & block_read);
			int_block_reg <= block_read & ivec_in_app & exec_in_boot;
		end
	end

endmodule // cbl_boot_gate

// ==== src/cbl_top.v ====
// Configuration bytes, lock byte, identity space and boot lock gating behind AXI4-Lite
// Operation
// - Boot lock mode 1: no limit on writes or reads of boot section.
// - Boot lock mode 2: self-programming writes to boot section blocked, reads allowed.
// - Boot lock mode 3: boot writes blocked, application reads of boot blocked.
// - Boot lock mode 4: boot writes allowed, application reads of boot blocked.
// - Modes 3 and 4, vectors in application: interrupts off inside boot section.
// - Three configuration bytes; programmed bit reads 0, unprogrammed reads 1.
// - Extended byte: brown-out level at 2..1, reset disable at 0, default ones.
// - High byte field order and defaults; scan, serial, boot size programmed.
// - Low byte: divide, clock out, start-up, source; default divide, RC 8 MHz.
// - Serial programming enable bit not accessible in serial programming mode.
// - Debug enable programmed keeps clock parts running in every sleep mode.
// - Clock output bit programmed drives system clock onto its port pin.
// - Preserve bit programmed keeps EEPROM contents through chip erase.
// - Chip erase leaves all configuration bits unchanged.
// - First application lock bit programmed refuses configuration changes.
// - Values latched on programming entry; changes act after leaving the mode.
// - EEPROM preserve bit acts immediately once programmed.
// - Values also latched at power-up in normal mode.
// - Three identity bytes at 0 to 2, readable even when locked.
// - Calibration byte at identity 0 high byte, copied to RC register in reset.
// - Lock bits return to 1 only by chip erase; here reset also reloads them as ones.
`timescale 1ns/100ps
`include "cbl_defs.vh"

module cbl_top
#(
	parameter [7:0] ID_BYTE0 = 8'h5a,  // Arbitrary identity value
	parameter [7:0] ID_BYTE1 = 8'h01,  // Arbitrary identity value
	parameter [7:0] ID_BYTE2 = 8'h02,  // Arbitrary identity value
	parameter [7:0] CAL_BYTE = 8'h80   // Arbitrary factory calibration
)
(
	input  wire        clk,
	input  wire        rst_b,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        spm_req,
	input  wire        spm_target_boot,
	input  wire        lpm_req,
	input  wire        lpm_target_boot,
	input  wire        exec_in_boot,
	input  wire        ivec_in_app,
	output wire        spm_grant,
	output wire        lpm_grant,
	output wire        int_block,
	output wire [7:0]  cfg_ext,
	output wire [7:0]  cfg_high,
	output wire [7:0]  cfg_low,
	output wire        eeprom_preserve,
	output wire        sleep_clock_keep,
	output wire        clock_output_enable,
	output wire        flash_erase,
	output wire        eeprom_erase,
	output wire [7:0]  rc_osc_calibration
);

	// ****************************************************************
	// State
	// ****************************************************************
	reg        awready_reg;
	reg        wready_reg;
	reg        bvalid_reg;
	reg [1:0]  bresp_reg;
	reg        arready_reg;
	reg        rvalid_reg;
	reg [1:0]  rresp_reg;
	reg [31:0] rdata_reg;
	reg [7:0]  waddr_reg;
	reg [31:0] wdata_reg;
	reg        wlane_reg;
	reg [7:0]  ext_img_reg;
	reg [7:0]  high_img_reg;
	reg [7:0]  low_img_reg;
	reg [7:0]  lock_img_reg;
	reg [7:0]  ext_eff_reg;
	reg [7:0]  high_eff_reg;
	reg [7:0]  low_eff_reg;
	reg        preserve_reg;
	reg        sleep_keep_reg;
	reg        clk_out_reg;
	reg        prog_reg;
	reg        serial_reg;
	reg        prog_prev_reg;
	reg        powerup_reg;
	reg        refused_reg;
	reg        flash_erase_reg;
	reg        eeprom_erase_reg;
	reg [7:0]  rc_cal_reg;

	wire       aw_held;
	wire       w_held;
	wire       do_write;
	wire       do_read;
	wire       app_locked;
	wire       latch_now;
	wire [1:0] cfg_sel;
	wire [7:0] cfg_data;
	wire [7:0] high_wr;
	wire       wr_cfg;
	wire       wr_lock;
	wire       wr_mode;
	wire       wr_status;
	wire       do_erase;
	wire       cfg_refused;
	reg [31:0] rdata_next;
	reg [1:0]  rresp_next;

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************
	// Address and data held once taken; either may come first
	assign aw_held  = ~awready_reg;
	assign w_held   = ~wready_reg;
	assign do_write = aw_held & w_held & ~bvalid_reg;

	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `CBL_RESP_OKAY;
			waddr_reg   <= 8'h00;
			wdata_reg   <= 32'h00000000;
			wlane_reg   <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
			begin
				awready_reg <= 1'b0;
				waddr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg)
			begin
				wready_reg <= 1'b0;
				wdata_reg  <= s_axi_wdata;
				wlane_reg  <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				bvalid_reg <= 1'b1;
				// Unmapped addresses get an error, no side effect
				if (waddr_reg == `CBL_OFF_CFG_WR || waddr_reg == `CBL_OFF_LOCK_WR ||
					waddr_reg == `CBL_OFF_MODE || waddr_reg == `CBL_OFF_STATUS)
					bresp_reg <= `CBL_RESP_OKAY;
				else if (waddr_reg[7:2] <= `CBL_OFF_LOW_EFF >> 2 && waddr_reg[1:0] == 2'h0)
					bresp_reg <= `CBL_RESP_OKAY;
				else
					bresp_reg <= `CBL_RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Write strobes for the registers; only the low lane strobe is checked, though the select bits 9:8 sit in lane 1
	assign wr_cfg    = do_write & wlane_reg & (waddr_reg == `CBL_OFF_CFG_WR);
	assign wr_lock   = do_write & wlane_reg & (waddr_reg == `CBL_OFF_LOCK_WR);
	assign wr_mode   = do_write & wlane_reg & (waddr_reg == `CBL_OFF_MODE);
	assign wr_status = do_write & wlane_reg & (waddr_reg == `CBL_OFF_STATUS);
	assign cfg_sel   = wdata_reg[9:8];
	assign cfg_data  = wdata_reg[7:0];

	// ****************************************************************
	// Nonvolatile images
	// ****************************************************************
	assign app_locked  = ~lock_img_reg[`CBL_LOCK_APP_FIRST];
	assign cfg_refused = wr_cfg & (~prog_reg | app_locked);
	assign do_erase    = wr_mode & prog_reg & wdata_reg[`CBL_MODE_ERASE];

	// Serial mode keeps the serial enable bit out of reach
	assign high_wr = serial_reg ?
		{cfg_data[7:6], high_img_reg[`CBL_HIGH_SERIAL_EN], cfg_data[4:0]} : cfg_data;

	// Images keep their value across chip erase except the lock byte
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			ext_img_reg  <= `CBL_EXT_DEFAULT;
			high_img_reg <= `CBL_HIGH_DEFAULT;
			low_img_reg  <= `CBL_LOW_DEFAULT;
			lock_img_reg <= `CBL_LOCK_DEFAULT;
		end
		else
		begin
			if (wr_cfg && !cfg_refused)
			begin
				if (cfg_sel == `CBL_SEL_EXT)
					ext_img_reg <= cfg_data | `CBL_EXT_UNUSED;
				else if (cfg_sel == `CBL_SEL_HIGH)
					high_img_reg <= high_wr;
				else if (cfg_sel == `CBL_SEL_LOW)
					low_img_reg <= cfg_data;
			end
			// Erase lets the lock byte go back to ones; plain writes only clear bits
			if (do_erase)
				lock_img_reg <= `CBL_LOCK_DEFAULT;
			else if (wr_lock && prog_reg)
				lock_img_reg <= lock_img_reg & (wdata_reg[7:0] | `CBL_LOCK_UNUSED);
		end
	end

	// ****************************************************************
	// Mode, status and erase pulses
	// ****************************************************************
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			prog_reg         <= 1'b0;
			serial_reg       <= 1'b0;
			prog_prev_reg    <= 1'b0;
			refused_reg      <= 1'b0;
			flash_erase_reg  <= 1'b0;
			eeprom_erase_reg <= 1'b0;
		end
		else
		begin
			prog_prev_reg <= prog_reg;
			if (wr_mode)
			begin
				prog_reg   <= wdata_reg[`CBL_MODE_PROG];
				serial_reg <= wdata_reg[`CBL_MODE_SERIAL];
			end
			// A new refusal beats a clear in the same cycle
			if (cfg_refused)
				refused_reg <= 1'b1;
			else if (wr_status && wdata_reg[0])
				refused_reg <= 1'b0;
			flash_erase_reg  <= do_erase;
			eeprom_erase_reg <= do_erase & ~preserve_reg;
		end
	end

	// ****************************************************************
	// Latched configuration
	// ****************************************************************
	// Latch at entry, at exit, and once after power-up in normal mode
	assign latch_now = (prog_reg ^ prog_prev_reg) | (powerup_reg & ~prog_reg);

	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			powerup_reg    <= 1'b1;
			ext_eff_reg    <= `CBL_EXT_DEFAULT;
			high_eff_reg   <= `CBL_HIGH_DEFAULT;
			low_eff_reg    <= `CBL_LOW_DEFAULT;
			preserve_reg   <= 1'b0;
			sleep_keep_reg <= 1'b0;
			clk_out_reg    <= 1'b0;
			rc_cal_reg     <= CAL_BYTE;
		end
		else
		begin
			powerup_reg <= 1'b0;
			if (latch_now)
			begin
				ext_eff_reg    <= ext_img_reg;
				high_eff_reg   <= high_img_reg;
				low_eff_reg    <= low_img_reg;
				sleep_keep_reg <= ~high_img_reg[`CBL_HIGH_DEBUG_EN];
				clk_out_reg    <= ~low_img_reg[`CBL_LOW_CLK_OUT];
			end
			// Preserve follows the image without waiting for a latch
			preserve_reg <= ~high_img_reg[`CBL_HIGH_EE_KEEP];
		end
	end

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************
	// Read mux; identity space ignores every lock
	always @*
	begin
		rdata_next = 32'h00000000;
		rresp_next = `CBL_RESP_OKAY;
		if (s_axi_araddr == `CBL_OFF_EXT_IMG)
			rdata_next = {24'h000000, ext_img_reg};
		else if (s_axi_araddr == `CBL_OFF_HIGH_IMG)
			rdata_next = {24'h000000, high_img_reg | {2'h0, serial_reg, 5'h00}};
		else if (s_axi_araddr == `CBL_OFF_LOW_IMG)
			rdata_next = {24'h000000, low_img_reg};
		else if (s_axi_araddr == `CBL_OFF_LOCK_IMG)
			rdata_next = {24'h000000, lock_img_reg};
		else if (s_axi_araddr == `CBL_OFF_CFG_WR || s_axi_araddr == `CBL_OFF_LOCK_WR)
			rdata_next = 32'h00000000;
		else if (s_axi_araddr == `CBL_OFF_MODE)
			rdata_next = {30'h00000000, serial_reg, prog_reg};
		else if (s_axi_araddr == `CBL_OFF_STATUS)
			rdata_next = {30'h00000000, app_locked, refused_reg};
		else if (s_axi_araddr == `CBL_OFF_ID0)
			rdata_next = {16'h0000, CAL_BYTE, ID_BYTE0};
		else if (s_axi_araddr == `CBL_OFF_ID1)
			rdata_next = {24'h000000, ID_BYTE1};
		else if (s_axi_araddr == `CBL_OFF_ID2)
			rdata_next = {24'h000000, ID_BYTE2};
		else if (s_axi_araddr == `CBL_OFF_RC_CAL)
			rdata_next = {24'h000000, rc_cal_reg};
		else if (s_axi_araddr == `CBL_OFF_EXT_EFF)
			rdata_next = {24'h000000, ext_eff_reg};
		else if (s_axi_araddr == `CBL_OFF_HIGH_EFF)
			rdata_next = {24'h000000, high_eff_reg};
		else if (s_axi_araddr == `CBL_OFF_LOW_EFF)
			rdata_next = {24'h000000, low_eff_reg};
		else
			rresp_next = `CBL_RESP_SLVERR;
	end

	// One read in flight; data sampled at the address handshake
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `CBL_RESP_OKAY;
			rdata_reg   <= 32'h00000000;
		end
		else
		begin
			if (s_axi_arvalid && arready_reg)
			begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rdata_reg   <= rdata_next;
				rresp_reg   <= rresp_next;
			end
			else if (rvalid_reg && s_axi_rready)
			begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Boot lock gate and outputs
	// ****************************************************************
	// Lock image acts at once so a freshly set boot lock protects immediately
	cbl_boot_gate u_gate
	(
		.clk             (clk),
		.rst_b           (rst_b),
		.boot_lock_upper (lock_img_reg[`CBL_LOCK_BOOT_UPPER]),
		.boot_lock_lower (lock_img_reg[`CBL_LOCK_BOOT_LOWER]),
		.spm_req         (spm_req),
		.spm_target_boot (spm_target_boot),
		.lpm_req         (lpm_req),
		.lpm_target_boot (lpm_target_boot),
		.exec_in_boot    (exec_in_boot),
		.ivec_in_app     (ivec_in_app),
		.spm_grant_reg   (spm_grant),
		.lpm_grant_reg   (lpm_grant),
		.int_block_reg   (int_block)
	);

	assign s_axi_awready       = awready_reg;
	assign s_axi_wready        = wready_reg;
	assign s_axi_bvalid        = bvalid_reg;
	assign s_axi_bresp         = bresp_reg;
	assign s_axi_arready       = arready_reg;
	assign s_axi_rvalid        = rvalid_reg;
	assign s_axi_rresp         = rresp_reg;
	assign s_axi_rdata         = rdata_reg;
	assign cfg_ext             = ext_eff_reg;
	assign cfg_high            = high_eff_reg;
	assign cfg_low             = low_eff_reg;
	assign eeprom_preserve     = preserve_reg;
	assign sleep_clock_keep    = sleep_keep_reg;
	assign clock_output_enable = clk_out_reg;
	assign flash_erase         = flash_erase_reg;
	assign eeprom_erase        = eeprom_erase_reg;
	assign rc_osc_calibration  = rc_cal_reg;

endmodule // cbl_top

// ==== bench/cbl_top_properties.sv ====
// Port-level assertions for the configuration and boot lock block
`timescale 1ns/100ps
`include "cbl_defs.vh"

module cbl_top_checker
#(
	parameter [7:0] CAL_BYTE = 8'h80
)
(
	input wire       clk,
	input wire       rst_b,
	input wire       spm_req,
	input wire       spm_target_boot,
	input wire       lpm_req,
	input wire       lpm_target_boot,
	input wire       exec_in_boot,
	input wire       ivec_in_app,
	input wire       spm_grant,
	input wire       lpm_grant,
	input wire       int_block,
	input wire [7:0] cfg_ext,
	input wire [7:0] cfg_high,
	input wire [7:0] cfg_low,
	input wire       eeprom_preserve,
	input wire       sleep_clock_keep,
	input wire       clock_output_enable,
	input wire       flash_erase,
	input wire       eeprom_erase,
	input wire [7:0] rc_osc_calibration
);
	// Single domain, reset masks all checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Gate answers one cycle after the request
	property p_spm_free; spm_req && !spm_target_boot |=> spm_grant; endproperty
	a_spm_free: assert property (p_spm_free) else $error("write outside boot refused");
	property p_lpm_boot; lpm_req && (exec_in_boot || !lpm_target_boot) |=> lpm_grant; endproperty
	a_lpm_boot: assert property (p_lpm_boot) else $error("program read refused");
	property p_int_cause; int_block |-> $past(ivec_in_app && exec_in_boot); endproperty
	a_int_cause: assert property (p_int_cause) else $error("interrupt block without cause");
	// Erase pulses and configuration side effects
	property p_ee_erase; flash_erase || eeprom_erase |-> eeprom_erase == (flash_erase && !eeprom_preserve); endproperty
	a_ee_erase: assert property (p_ee_erase) else $error("eeprom erase disagrees with preserve");
	property p_dbg_clk; $stable(cfg_high) |-> sleep_clock_keep == !cfg_high[`CBL_HIGH_DEBUG_EN]; endproperty
	a_dbg_clk: assert property (p_dbg_clk) else $error("sleep clock keep wrong");
	property p_clk_out; $stable(cfg_low) |-> clock_output_enable == !cfg_low[`CBL_LOW_CLK_OUT]; endproperty
	a_clk_out: assert property (p_clk_out) else $error("clock output enable wrong");
	property p_unused; cfg_ext[7:3] == 5'h1f; endproperty
	a_unused: assert property (p_unused) else $error("unused extended bits not one");
	property p_cal; rc_osc_calibration == CAL_BYTE; endproperty
	a_cal: assert property (p_cal) else $error("calibration copy wrong");

	// Main scenarios reached
	c_ee_kept: cover property (flash_erase && !eeprom_erase);
	c_ee_wiped: cover property (flash_erase && eeprom_erase);
	c_int_off: cover property (int_block);
endmodule  // cbl_top_checker

bind cbl_top cbl_top_checker #(.CAL_BYTE(CAL_BYTE)) i_chk
(
	.clk(clk), .rst_b(rst_b), .spm_req(spm_req), .spm_target_boot(spm_target_boot), .lpm_req(lpm_req),
	.lpm_target_boot(lpm_target_boot), .exec_in_boot(exec_in_boot), .ivec_in_app(ivec_in_app),
	.spm_grant(spm_grant), .lpm_grant(lpm_grant), .int_block(int_block), .cfg_ext(cfg_ext),
	.cfg_high(cfg_high), .cfg_low(cfg_low), .eeprom_preserve(eeprom_preserve),
	.sleep_clock_keep(sleep_clock_keep), .clock_output_enable(clock_output_enable),
	.flash_erase(flash_erase), .eeprom_erase(eeprom_erase), .rc_osc_calibration(rc_osc_calibration)
);

// ==== bench/cbl_prog_model.sv ====
// Programmer model: AXI4-Lite master for the register port
`timescale 1ns/100ps

module cbl_prog_model
(
	input  wire         clk,
	output logic [7:0]  awaddr,
	output logic        awvalid,
	input  wire         awready,
	output logic [31:0] wdata,
	output logic [3:0]  wstrb,
	output logic        wvalid,
	input  wire         wready,
	input  wire  [1:0]  bresp,
	input  wire         bvalid,
	output logic        bready,
	output logic [7:0]  araddr,
	output logic        arvalid,
	input  wire         arready,
	input  wire  [31:0] rdata,
	input  wire  [1:0]  rresp,
	input  wire         rvalid,
	output logic        rready,
	input  wire         slow,
	output logic        hung
);
	// Idle bus at time zero
	initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;

	// One write; released payload is inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tw, tb;
		{awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hf, 2'b11};
		for (n = 0; n < 64; n++)
		begin
			// Handshakes judged on settled values, acted on at the next rising edge
			@(negedge clk);
			{ta, tw, tb, r} = {awvalid && awready, wvalid && wready, bready && bvalid, bresp};
			@(posedge clk);
			if (ta) {awvalid, awaddr} <= {1'b0, ~awaddr};
			if (tw) {wvalid, wdata} <= {1'b0, ~wdata};
			if (tb) break;
			if (!slow || n > 2) bready <= 1'b1;  // Slow mode stalls the response
		end
		bready <= 1'b0;
		if (n == 64) hung <= 1'b1;
	endtask

	// One read, same stall option
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tb;
		{araddr, arvalid} <= {a, 1'b1};
		for (n = 0; n < 64; n++)
		begin
			@(negedge clk);
			{ta, tb, d, r} = {arvalid && arready, rready && rvalid, rdata, rresp};
			@(posedge clk);
			if (ta) {arvalid, araddr} <= {1'b0, ~araddr};
			if (tb) break;
			if (!slow || n > 2) rready <= 1'b1;
		end
		rready <= 1'b0;
		if (n == 64) hung <= 1'b1;
	endtask
endmodule  // cbl_prog_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the configuration and boot lock block
`timescale 1ns/100ps
`include "cbl_defs.vh"

module tb_top;
	localparam [7:0] ID0 = 8'h3c;  // Arbitrary value
	localparam [7:0] ID1 = 8'h4d;  // Arbitrary value
	localparam [7:0] ID2 = 8'h5e;  // Arbitrary value
	localparam [7:0] CAL = 8'ha7;  // Arbitrary value
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        slow = 1'b0;
	logic [5:0]  cpu = 6'h00;  // spm, spm boot, lpm, lpm boot, exec boot, vectors app
	wire  [7:0]  awaddr, araddr, cfg_ext, cfg_high, cfg_low, rc_osc_calibration;
	wire  [31:0] wdata, rdata;
	wire  [3:0]  wstrb;
	wire  [1:0]  bresp, rresp;
	wire         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, hung;
	wire         spm_grant, lpm_grant, int_block, eeprom_preserve, sleep_clock_keep, clock_output_enable;
	wire         flash_erase, eeprom_erase;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          fe_cnt = 0;
	int          ee_cnt = 0;

	cbl_top #(.ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2), .CAL_BYTE(CAL)) i_dut
	(
		.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .spm_req(cpu[5]), .spm_target_boot(cpu[4]),
		.lpm_req(cpu[3]), .lpm_target_boot(cpu[2]), .exec_in_boot(cpu[1]), .ivec_in_app(cpu[0]),
		.spm_grant(spm_grant), .lpm_grant(lpm_grant), .int_block(int_block), .cfg_ext(cfg_ext),
		.cfg_high(cfg_high), .cfg_low(cfg_low), .eeprom_preserve(eeprom_preserve),
		.sleep_clock_keep(sleep_clock_keep), .clock_output_enable(clock_output_enable),
		.flash_erase(flash_erase), .eeprom_erase(eeprom_erase), .rc_osc_calibration(rc_osc_calibration)
	);

	cbl_prog_model i_prog
	(
		.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.slow(slow), .hung(hung)
	);

	// 100 MHz clock; erase pulses counted as they pass
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		fe_cnt <= fe_cnt + int'(flash_erase === 1'b1);
		ee_cnt <= ee_cnt + int'(eeprom_erase === 1'b1);
		if (hung === 1'b1)
		begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus helpers expecting an OKAY answer
	task automatic wrc(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_prog.wr(a, d, r);
		chk({30'h0, r}, {30'h0, `CBL_RESP_OKAY});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		i_prog.rd(a, d, r);
		chk({30'h0, r}, {30'h0, `CBL_RESP_OKAY});
		chk(d, e);
	endtask
	task automatic cfg(input logic [1:0] sel, input logic [7:0] v);
		wrc(`CBL_OFF_CFG_WR, {22'h0, sel, v});
	endtask

	// Defaults, identity space, read-only and unmapped places
	task automatic t_defaults();
		logic [31:0] d;
		logic [1:0]  r;
		rdc(`CBL_OFF_EXT_IMG, 32'hff);
		rdc(`CBL_OFF_HIGH_IMG, 32'h99);
		rdc(`CBL_OFF_LOW_IMG, 32'h62);
		rdc(`CBL_OFF_LOCK_IMG, 32'hff);
		rdc(`CBL_OFF_HIGH_EFF, 32'h99);
		rdc(`CBL_OFF_ID0, {16'h0, CAL, ID0});
		rdc(`CBL_OFF_ID2, {24'h0, ID2});
		rdc(`CBL_OFF_RC_CAL, {24'h0, CAL});
		wrc(`CBL_OFF_HIGH_IMG, 32'h0);
		rdc(`CBL_OFF_HIGH_IMG, 32'h99);
		i_prog.rd(8'h3c, d, r);
		chk({30'h0, r}, {30'h0, `CBL_RESP_SLVERR});
		$display("defaults done");
	endtask

	// Writes land in the image; preserve acts at once, the rest only after leaving programming mode
	task automatic t_latch();
		cfg(`CBL_SEL_LOW, 8'h22);
		rdc(`CBL_OFF_LOW_IMG, 32'h62);
		rdc(`CBL_OFF_STATUS, 32'h1);
		wrc(`CBL_OFF_STATUS, 32'h1);
		wrc(`CBL_OFF_MODE, 32'h1);
		cfg(`CBL_SEL_LOW, 8'h22);
		cfg(`CBL_SEL_HIGH, 8'h11);
		cfg(`CBL_SEL_EXT, 8'h02);
		rdc(`CBL_OFF_EXT_IMG, 32'hfa);
		rdc(`CBL_OFF_LOW_EFF, 32'h62);
		chk({30'h0, eeprom_preserve, clock_output_enable}, 32'h2);
		wrc(`CBL_OFF_MODE, 32'h0);
		repeat (2) @(posedge clk);
		chk({8'h0, cfg_ext, cfg_high, cfg_low}, 32'hfa1122);
		chk({30'h0, sleep_clock_keep, clock_output_enable}, 32'h3);
		$display("latch done");
	endtask

	// Serial programming enable bit hidden and kept in serial mode
	task automatic t_serial();
		wrc(`CBL_OFF_MODE, 32'h3);
		rdc(`CBL_OFF_HIGH_IMG, 32'h31);
		cfg(`CBL_SEL_HIGH, 8'hff);
		wrc(`CBL_OFF_MODE, 32'h1);
		rdc(`CBL_OFF_HIGH_IMG, 32'hdf);
		chk({31'h0, eeprom_preserve}, 32'h0);
		$display("serial done");
	endtask

	// Chip erase with and without preserve, then the application lock
	task automatic t_erase_lock();
		wrc(`CBL_OFF_MODE, 32'h5);
		repeat (2) @(posedge clk);
		chk({fe_cnt[15:0], ee_cnt[15:0]}, 32'h10001);
		cfg(`CBL_SEL_HIGH, 8'hd7);
		wrc(`CBL_OFF_MODE, 32'h5);
		repeat (2) @(posedge clk);
		chk({fe_cnt[15:0], ee_cnt[15:0]}, 32'h20001);
		rdc(`CBL_OFF_HIGH_IMG, 32'hd7);
		rdc(`CBL_OFF_LOW_IMG, 32'h22);
		wrc(`CBL_OFF_LOCK_WR, 32'h0);
		cfg(`CBL_SEL_LOW, 8'h00);
		rdc(`CBL_OFF_LOW_IMG, 32'h22);
		rdc(`CBL_OFF_STATUS, 32'h3);
		rdc(`CBL_OFF_ID1, {24'h0, ID1});
		wrc(`CBL_OFF_LOCK_WR, 32'hff);
		rdc(`CBL_OFF_LOCK_IMG, 32'hc0);
		wrc(`CBL_OFF_MODE, 32'h5);
		rdc(`CBL_OFF_LOCK_IMG, 32'hff);
		wrc(`CBL_OFF_STATUS, 32'h1);
		$display("erase and lock done");
	endtask

	task automatic cpu_chk(input logic [5:0] c, input logic [2:0] e);
		cpu <= c;
		repeat (2) @(posedge clk);
		chk({29'h0, spm_grant, lpm_grant, int_block}, {29'h0, e});
	endtask

	// All four boot lock modes, upper then lower bit
	task automatic t_gate();
		logic [1:0] m [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
		for (int i = 0; i < 4; i++)
		begin
			wrc(`CBL_OFF_MODE, 32'h5);
			wrc(`CBL_OFF_LOCK_WR, {26'h0, m[i], 4'hf});
			cpu_chk(6'b111101, {m[i][0], m[i][1], 1'b0});
			cpu_chk(6'b111111, {m[i][0], 1'b1, ~m[i][1]});
			cpu_chk(6'b101000, 3'b110);
		end
		cpu <= 6'h00;
		$display("gate done");
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		slow <= 1'b1;
		t_defaults();
		slow <= 1'b0;
		t_latch();
		t_serial();
		t_erase_lock();
		t_gate();
		end_of_test();
	end
endmodule  // tb_top
